/* core/mshs_pkg.sv */
// Shared types and constants for the multi-unit start/halt coordinator.
// Assumes one 50 MHz system clock and open-collector peer lines.
package mshs_pkg;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int unsigned CLK_PERIOD_NS    = 20;
    // Least time the halt line is held low after a unit stops
    localparam int unsigned HALT_HOLD_NS     = 100;
    localparam int unsigned HALT_HOLD_CYCLES =
        (HALT_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned HOLD_CNT_W       = 8;
    // Cycles a new member waits before trusting the synchronised line
    localparam logic [1:0]  JOIN_SETTLE_CYCLES = 2'h2;

    // ************************************************************
    // Reset values and encodings
    // ************************************************************
    localparam logic [1:0] ROLE_CODE_INDEP  = 2'h0;
    localparam logic [1:0] ROLE_CODE_MASTER = 2'h1;
    localparam logic [1:0] ROLE_CODE_SLAVE  = 2'h2;
    localparam logic       JOINT_RESET      = 1'h0;
    localparam logic       LINE_RELEASED    = 1'h1;

    typedef enum logic [1:0] {
        INDEPENDENT_ROLE = ROLE_CODE_INDEP,
        MASTER_ROLE      = ROLE_CODE_MASTER,
        SLAVE_ROLE       = ROLE_CODE_SLAVE
    } mshs_role_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WAIT,
        ST_RUN
    } mshs_state_t;

    // ************************************************************
    // Carriers
    // ************************************************************
    // One-cycle command strobes from the operator side
    typedef struct packed {
        logic role_setup_command;
        logic run_command;
        logic halt_command;
        logic group_run_command;
        logic group_halt_command;
        logic total_run_command;
    } mshs_cmd_t;

    // Values loaded by role_setup_command
    typedef struct packed {
        logic [1:0] role;
        logic       joint_start_flag;
    } mshs_cfg_t;

endpackage

/* core/mshs_sync.sv */
// Two-flop synchroniser for one level from a shared peer line.
// Assumes the line may change at any time relative to the clock.
`timescale 1ns/1ps
module mshs_sync
    import mshs_pkg::*;
(
    input  wire logic clk_i,    // System clock
    input  wire logic rst_b_i,  // Async reset, active low
    input  wire logic d_i,      // Asynchronous level
    output logic      q_o       // Synchronised level
);

    logic meta;

    // First stage feeds only the second; resets to an idle line
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            meta <= LINE_RELEASED;
            q_o  <= LINE_RELEASED;
        end else begin
            meta <= d_i;
            q_o  <= meta;
        end
    end

endmodule

/* core/mshs_hold.sv */
// Retriggerable hold timer: output high for a set number of cycles.
// Assumes the trigger is a one-cycle pulse on the same clock.
`timescale 1ns/1ps
module mshs_hold
    import mshs_pkg::*;
#(
    parameter int unsigned CYCLES = HALT_HOLD_CYCLES
) (
    input  wire logic clk_i,    // System clock
    input  wire logic rst_b_i,  // Async reset, active low
    input  wire logic trig_i,   // Start or restart the hold
    output logic      active_o  // High while holding
);

    logic [HOLD_CNT_W-1:0] count;
    logic [HOLD_CNT_W-1:0] next_count;
    logic                  next_active;

    always_comb begin
        next_count = count;
        if (trig_i) begin
            next_count = HOLD_CNT_W'(CYCLES);
        end else if (count != '0) begin
            next_count = count - HOLD_CNT_W'(1);
        end
        next_active = (next_count != '0);
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            count    <= '0;
            active_o <= 1'b0;
        end else begin
            count    <= next_count;
            active_o <= next_active;
        end
    end

endmodule

/* core/mshs_top.sv */
// Start/halt coordinator for one unit in a chain of emulator units.
// Assumes peers share two open-collector lines (ready, halt), pulled up
// externally, and that operator commands arrive as one-cycle strobes.
`timescale 1ns/1ps

// Contract
// - Role 0 independent, 1 master, 2 slave
// - Joint-start flag, reset to not joined
// - Slave always counts as joined
// - Group commands act only on joined units
// - Unjoined unit runs at once on run
// - Joined unit waits for all joined ready
// - Master starts no earlier than slaves
// - Slave starts when masters and slaves ready
// - Role affects starting only by making a slave joined
// - Master or slave stop halts all slaves
// - Group run starts joined units together
// - Held-back joined unit reports waiting state
// - Total run starts unit unconditionally; in the code a halt in the same cycle wins while waiting
module mshs_top
    import mshs_pkg::*;
#(
    parameter int unsigned HOLD_CYCLES = HALT_HOLD_CYCLES
) (
    input  wire logic       SYS_CLK_I,      // 50 MHz system clock
    input  wire logic       RST_B_I,        // Async reset, active low
    input  wire mshs_cmd_t  CMD_I,          // Operator command strobes
    input  wire mshs_cfg_t  CFG_I,          // Values for role setup
    input  wire logic       READY_LINE_I,   // Shared ready line level
    output logic            READY_LINE_O,   // Ready line drive value
    output logic            READY_LINE_OE_O,// Pull ready line low
    input  wire logic       HALT_LINE_I,    // Shared halt line level
    output logic            HALT_LINE_O,    // Halt line drive value
    output logic            HALT_LINE_OE_O, // Pull halt line low
    output mshs_role_t      ROLE_O,         // Current role
    output logic            JOINED_O,       // Effective joint membership
    output logic            WAITING_O,      // Waiting to run
    output logic            RUNNING_O       // Running
);

    // ************************************************************
    // Peer line synchronisers
    // ************************************************************
    logic ready_line_s;
    logic halt_line_s;

    mshs_sync u_ready_sync (
        .clk_i   (SYS_CLK_I),
        .rst_b_i (RST_B_I),
        .d_i     (READY_LINE_I),
        .q_o     (ready_line_s)
    );

    mshs_sync u_halt_sync (
        .clk_i   (SYS_CLK_I),
        .rst_b_i (RST_B_I),
        .d_i     (HALT_LINE_I),
        .q_o     (halt_line_s)
    );

    // ************************************************************
    // Configuration
    // ************************************************************
    mshs_role_t role;
    mshs_role_t next_role;
    logic       joint_flag;
    logic       next_joint_flag;
    logic       joined;

    always_comb begin
        next_role       = role;
        next_joint_flag = joint_flag;
        if (CMD_I.role_setup_command) begin
            unique case (CFG_I.role)
                ROLE_CODE_MASTER: next_role = MASTER_ROLE;
                ROLE_CODE_SLAVE:  next_role = SLAVE_ROLE;
                // Undefined code 3 falls back to independent
                default:          next_role = INDEPENDENT_ROLE;
            endcase
            next_joint_flag = CFG_I.joint_start_flag;
        end
    end

    always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            role       <= INDEPENDENT_ROLE;
            joint_flag <= JOINT_RESET;
        end else begin
            role       <= next_role;
            joint_flag <= next_joint_flag;
        end
    end

    assign joined = joint_flag | (role == SLAVE_ROLE);

    // ************************************************************
    // Ready line settle guard
    // ************************************************************
    // The synchronised line trails our own pull by the synchroniser depth;
    // a unit that has only just joined would otherwise read a stale
    // released level and start ahead of peers that joined with it.
    logic [1:0] join_age;
    logic [1:0] next_join_age;
    logic       line_settled;

    always_comb begin
        next_join_age = join_age;
        if (!joined) begin
            next_join_age = 2'h0;
        end else if (join_age != JOIN_SETTLE_CYCLES) begin
            next_join_age = join_age + 2'h1;
        end
    end

    always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            join_age <= 2'h0;
        end else begin
            join_age <= next_join_age;
        end
    end

    // no start on a stale line sample
    assign line_settled = (join_age == JOIN_SETTLE_CYCLES);

    // ************************************************************
    // Run state
    // ************************************************************
    mshs_state_t state;
    mshs_state_t next_state;
    logic        own_stop;
    logic        start_cmd;
    logic        halt_cmd;

    always_comb begin
        start_cmd = CMD_I.run_command | (CMD_I.group_run_command & joined);
        halt_cmd  = CMD_I.halt_command | (CMD_I.group_halt_command & joined);
    end

    always_comb begin
        next_state = state;
        own_stop   = 1'b0;
        unique case (state)
            ST_IDLE: begin
                if (CMD_I.total_run_command) begin
                    next_state = ST_RUN;
                end else if (start_cmd) begin
                    next_state = joined ? ST_WAIT : ST_RUN;
                end
            end
            ST_WAIT: begin
                if (halt_cmd) begin
                    next_state = ST_IDLE;
                end else if (CMD_I.total_run_command || !joined) begin
                    next_state = ST_RUN;
                // released line starts all at once
                end else if (line_settled && ready_line_s == LINE_RELEASED) begin
                    next_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (halt_cmd) begin
                    next_state = ST_IDLE;
                    own_stop   = 1'b1;
                end else if (role == SLAVE_ROLE && halt_line_s != LINE_RELEASED) begin
                    next_state = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // ************************************************************
    // Halt line pulse
    // ************************************************************
    // Only a stop of our own making is broadcast; a slave stopped by the
    // line stays quiet, otherwise slaves would retrigger one another.
    logic halt_trig;

    assign halt_trig = own_stop & (role != INDEPENDENT_ROLE);

    // hold flop drives halt pull
    // Taken straight from the hold flop so the pull starts with the stop
    mshs_hold #(
        .CYCLES (HOLD_CYCLES)
    ) u_halt_hold (
        .clk_i    (SYS_CLK_I),
        .rst_b_i  (RST_B_I),
        .trig_i   (halt_trig),
        .active_o (HALT_LINE_OE_O)
    );

    // ************************************************************
    // Registered outputs
    // ************************************************************
    logic next_joined;
    logic next_ready_oe;
    logic next_waiting;
    logic next_running;

    always_comb begin
        next_joined   = next_joint_flag | (next_role == SLAVE_ROLE);
        // pull ready low only when joined and idle
        // Hazard: a joined idle unit must hold the line so no peer starts
        // ahead of it; running units release so late joiners see no block.
        next_ready_oe = next_joined && (next_state == ST_IDLE);
        next_waiting  = (next_state == ST_WAIT);
        next_running  = (next_state == ST_RUN);
    end

    always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            READY_LINE_O    <= 1'b0;
            READY_LINE_OE_O <= 1'b0;
            HALT_LINE_O     <= 1'b0;
            ROLE_O          <= INDEPENDENT_ROLE;
            JOINED_O        <= 1'b0;
            WAITING_O       <= 1'b0;
            RUNNING_O       <= 1'b0;
        end else begin
            // Open collector: drive value stays low, the enable does the work
            READY_LINE_O    <= 1'b0;
            READY_LINE_OE_O <= next_ready_oe;
            HALT_LINE_O     <= 1'b0;
            ROLE_O          <= next_role;
            JOINED_O        <= next_joined;
            WAITING_O       <= next_waiting;
            RUNNING_O       <= next_running;
        end
    end

endmodule

/* verif/mshs_top_asserts.sv */
// Port-level checks for the start/halt coordinator.
// Assumes HOLD_CYCLES of at least 3 and two-flop line synchronisers.
`timescale 1ns/1ps
module mshs_top_asserts
    import mshs_pkg::*;
#(
    parameter int unsigned HOLD_CYCLES = HALT_HOLD_CYCLES
) (
    input wire logic       SYS_CLK_I,       // Clock
    input wire logic       RST_B_I,         // Reset, active low
    input wire mshs_cmd_t  CMD_I,           // Commands
    input wire mshs_cfg_t  CFG_I,           // Setup values
    input wire logic       READY_LINE_I,    // Ready line
    input wire logic       READY_LINE_O,    // Ready drive
    input wire logic       READY_LINE_OE_O, // Ready pull
    input wire logic       HALT_LINE_I,     // Halt line
    input wire logic       HALT_LINE_O,     // Halt drive
    input wire logic       HALT_LINE_OE_O,  // Halt pull
    input wire mshs_role_t ROLE_O,          // Role
    input wire logic       JOINED_O,        // Joined
    input wire logic       WAITING_O,       // Waiting
    input wire logic       RUNNING_O        // Running
);
    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (!RST_B_I);
    logic       idle;
    logic [5:0] c;
    assign idle = !RUNNING_O && !WAITING_O;
    assign c    = CMD_I;

    role_load_a: assert property (c[5] |=> ROLE_O == (($past(CFG_I.role) == 2'h3) ?
        2'h0 : $past(CFG_I.role))) else $error("role not loaded");
    join_load_a: assert property (c[5] |=> JOINED_O ==
        ($past(CFG_I.joint_start_flag) || $past(CFG_I.role) == 2'h2)) else $error("bad join");
    indep_run_a: assert property (idle && !JOINED_O && c == 6'h10 |=> RUNNING_O)
        else $error("unjoined run late");
    join_wait_a: assert property (idle && JOINED_O && c == 6'h10 |=> WAITING_O && !RUNNING_O)
        else $error("joined run not held");
    group_skip_a: assert property (idle && !JOINED_O && c == 6'h04 |=> idle)
        else $error("group run taken");
    total_run_a: assert property (!RUNNING_O && c == 6'h01 |=> RUNNING_O)
        else $error("total run ignored");
    ready_pull_a: assert property (READY_LINE_OE_O == (JOINED_O && idle))
        else $error("ready pull wrong");
    drive_low_a: assert property (!READY_LINE_O && !HALT_LINE_O)
        else $error("line driven high");
    own_halt_a: assert property (RUNNING_O && ROLE_O != INDEPENDENT_ROLE && c == 6'h08
        |=> !RUNNING_O ##0 HALT_LINE_OE_O [*3]) else $error("halt not broadcast");
    slave_stop_a: assert property (RUNNING_O && ROLE_O == SLAVE_ROLE ##0 !HALT_LINE_I [*3]
        |=> !RUNNING_O) else $error("slave kept running");
    line_start_a: assert property ($rose(RUNNING_O) && JOINED_O && $past(WAITING_O)
        && $past(c) == 6'h00 |-> $past(READY_LINE_I, 3)) else $error("start before ready");
    indep_keep_a: assert property (RUNNING_O && ROLE_O == INDEPENDENT_ROLE && c == 6'h00
        |=> RUNNING_O) else $error("independent stopped");

    cover property (WAITING_O ##1 RUNNING_O);
    cover property ($rose(HALT_LINE_OE_O));
    cover property (RUNNING_O && ROLE_O == SLAVE_ROLE ##1 !RUNNING_O);
endmodule

bind mshs_top mshs_top_asserts #(.HOLD_CYCLES(HOLD_CYCLES)) chk_u (
    .SYS_CLK_I(SYS_CLK_I), .RST_B_I(RST_B_I), .CMD_I(CMD_I), .CFG_I(CFG_I),
    .READY_LINE_I(READY_LINE_I), .READY_LINE_O(READY_LINE_O),
    .READY_LINE_OE_O(READY_LINE_OE_O), .HALT_LINE_I(HALT_LINE_I),
    .HALT_LINE_O(HALT_LINE_O), .HALT_LINE_OE_O(HALT_LINE_OE_O), .ROLE_O(ROLE_O),
    .JOINED_O(JOINED_O), .WAITING_O(WAITING_O), .RUNNING_O(RUNNING_O));

/* verif/mshs_peer.sv */
// Peer unit model: pulls the shared ready and halt lines.
// Assumes the bench merges the pulls into pulled-up lines.
`timescale 1ns/1ps
module mshs_peer
    import mshs_pkg::*;
(
    input  wire logic clk_i,      // Clock
    input  wire logic rst_b_i,    // Reset, active low
    input  wire logic hold_i,     // Not yet ready to run
    input  wire logic stop_i,     // Own stop, one cycle
    output logic      ready_oe_o, // Pull ready line low
    output logic      halt_oe_o   // Pull halt line low
);
    logic [2:0] cnt;
    logic [2:0] next_cnt;
    always_comb begin
        next_cnt = stop_i ? 3'h3 : ((cnt != 3'h0) ? cnt - 3'h1 : cnt);
    end
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt        <= 3'h0;
            ready_oe_o <= 1'h0;
        end else begin
            cnt        <= next_cnt;
            ready_oe_o <= hold_i;
        end
    end
    assign halt_oe_o = (cnt != 3'h0);
endmodule

/* verif/mshs_top_tb.sv */
// Self-checking bench: one coordinator facing one peer model.
// Assumes the checker is bound and HOLD_CYCLES is set to 3.
`timescale 1ns/1ps
`define CHK(n, e, s) begin cmp_count++; if ((e) !== (s)) begin mismatches++; \
    $display("Error %s expected %h seen %h", n, e, s); end end
module mshs_top_tb
    import mshs_pkg::*;
;
    logic       clk = 1'h0;
    logic       rst_b = 1'h0;
    mshs_cmd_t  cmd = '0;
    mshs_cfg_t  cfg = '0;
    logic       p_hold = 1'h0;
    logic       p_stop = 1'h0;
    logic       chk = 1'h0;
    logic       r_o, r_oe, h_o, h_oe, p_r_oe, p_h_oe, waiting, running, joined;
    logic [4:0] got;
    mshs_role_t role;
    int         mismatches = 0;
    int         cmp_count = 0;
    logic [4:0] exp_q[$];
    wire        r_w = (r_oe ? r_o : 1'h1) & !p_r_oe;
    wire        h_w = (h_oe ? h_o : 1'h1) & !p_h_oe;
    always #10 clk = !clk;
    mshs_top #(.HOLD_CYCLES(3)) dut_u (.SYS_CLK_I(clk), .RST_B_I(rst_b), .CMD_I(cmd),
        .CFG_I(cfg), .READY_LINE_I(r_w), .READY_LINE_O(r_o), .READY_LINE_OE_O(r_oe),
        .HALT_LINE_I(h_w), .HALT_LINE_O(h_o), .HALT_LINE_OE_O(h_oe), .ROLE_O(role),
        .JOINED_O(joined), .WAITING_O(waiting), .RUNNING_O(running));
    mshs_peer peer_u (.clk_i(clk), .rst_b_i(rst_b), .hold_i(p_hold), .stop_i(p_stop),
        .ready_oe_o(p_r_oe), .halt_oe_o(p_h_oe));

    task automatic finish_test();
        if (mismatches == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask
    task automatic send(input logic [5:0] c);
        cmd = c;
        tick(1);
        cmd = '0;
    endtask
    task automatic setup(input logic [1:0] r, input logic f);
        cfg = {r, f};
        send(6'h20);
    endtask
    // Note the expected state; the monitor compares at the next edge
    task automatic expect_st(input logic [4:0] e);
        exp_q.push_back(e);
        chk = 1'h1;
        tick(1);
        chk = 1'h0;
    endtask
    // Bounded wait for the running flag to reach a level
    task automatic wait_run(input logic v);
        for (int n = 0; n < 12 && running !== v; n++) tick(1);
    endtask
    task automatic peer_stop();
        p_stop = 1'h1;
        tick(1);
        p_stop = 1'h0;
    endtask

    always @(posedge clk) begin
        if (chk) begin
            got = exp_q.pop_front();
            `CHK("state", got, {role, joined, waiting, running})
        end
    end
    initial begin
        #100000;
        mismatches++;
        finish_test();
    end
    initial begin
        logic f;
        void'($urandom(28));
        tick(5);
        rst_b = 1'h1;
        expect_st(5'h00);
        for (int i = 0; i < 4; i++) begin
            f = 1'($urandom());
            setup(2'(i), f);
            expect_st({(i == 3) ? 2'h0 : 2'(i), f | (i == 2), 2'h0});
        end
        setup(2'h0, 1'h0);
        send(6'h10);
        expect_st(5'h01);
        send(6'h02);
        expect_st(5'h01);
        peer_stop();
        tick(3);
        expect_st(5'h01);
        send(6'h08);
        `CHK("halt_oe", 1'h0, h_oe)
        send(6'h04);
        expect_st(5'h00);
        p_hold = 1'h1;
        setup(2'h1, 1'h1);
        send(6'h10);
        expect_st(5'h0E);
        tick(8);
        expect_st(5'h0E);
        `CHK("ready_oe", 1'h0, r_oe)
        p_hold = 1'h0;
        wait_run(1'h1);
        expect_st(5'h0D);
        send(6'h08);
        `CHK("halt_oe", 1'h1, h_oe)
        expect_st(5'h0C);
        `CHK("ready_oe", 1'h1, r_oe)
        `CHK("line_drive", 2'h0, {r_o, h_o})
        setup(2'h2, 1'h0);
        send(6'h04);
        expect_st(5'h16);
        wait_run(1'h1);
        expect_st(5'h15);
        peer_stop();
        wait_run(1'h0);
        expect_st(5'h14);
        p_hold = 1'h1;
        tick(2);
        send(6'h01);
        expect_st(5'h15);
        send(6'h08);
        `CHK("halt_oe", 1'h1, h_oe)
        tick(4);
        setup(2'h0, 1'h1);
        send(6'h04);
        expect_st(5'h06);
        send(6'h08);
        expect_st(5'h04);
        tick(2);
        finish_test();
    end
endmodule
